/* File: common/bsd_pkg.sv */
package bsd_pkg;

  // ------------------------------------------------------------------
  // Register map (word aligned byte addresses).
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_STRAP   = 8'h00;
  localparam logic [7:0] OFS_FUSE    = 8'h04;
  localparam logic [7:0] OFS_FPROG   = 8'h08;
  localparam logic [7:0] OFS_DECODE  = 8'h0c;
  localparam logic [7:0] OFS_ID      = 8'h10;

  // Arbitrary identification value.
  localparam logic [31:0] ID_VALUE   = 32'h0000b5d1;

  // ------------------------------------------------------------------
  // Strap vector bit positions.
  // ------------------------------------------------------------------
  localparam int STRAP_W       = 5;
  localparam int SB_BOOT_LOW   = 0;
  localparam int SB_BOOT_HIGH  = 1;
  localparam int SB_SMP_EDGE   = 2;
  localparam int SB_OUT_EDGE   = 3;
  localparam int SB_DBG_SRC    = 4;

  // ------------------------------------------------------------------
  // Fuse vector bit positions.
  // ------------------------------------------------------------------
  localparam int FUSE_W        = 7;
  localparam int FB_PRINT_LO   = 0;
  localparam int FB_PRINT_HI   = 1;
  localparam int FB_USB_DIS    = 2;
  localparam int FB_USB_PRTDIS = 3;
  localparam int FB_PAD_DBGDIS = 4;
  localparam int FB_USB_DBGDIS = 5;
  localparam int FB_DBG_SELEN  = 6;

  // Values after reset.
  localparam logic [FUSE_W-1:0]  FUSE_RESET  = 7'h00;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 5'h00;

  // Strap hold time before capture, in the clock domain.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int STRAP_HOLD_MS  = 3;
  localparam int STRAP_HOLD_CYC = STRAP_HOLD_MS * 1000000 / CLK_PERIOD_NS;

  // Boot mode and debug source encodings.
  localparam logic [1:0] BOOT_NONE  = 2'h0;
  localparam logic [1:0] BOOT_FLASH = 2'h1;
  localparam logic [1:0] BOOT_DL    = 2'h2;
  localparam logic [1:0] DBG_OFF    = 2'h0;
  localparam logic [1:0] DBG_USB    = 2'h1;
  localparam logic [1:0] DBG_PINS   = 2'h2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/bsd_decode.sv */
`timescale 1ns/1ns
module bsd_decode
  import bsd_pkg::*;
(
  input  wire logic [STRAP_W-1:0] strap,
  input  wire logic [FUSE_W-1:0]  fuse,
  output logic      [1:0]         boot_mode,
  output logic                    sdio_sample_rise,
  output logic                    sdio_output_rise,
  output logic                    print_serial,
  output logic                    print_usb,
  output logic      [1:0]         debug_source
);

  // ------------------------------------------------------------------
  // Option decode
  // ------------------------------------------------------------------

  // Pure combinational decode of latched straps and fuses.
  always_comb begin
    logic [1:0] pol;
    pol = {fuse[FB_PRINT_HI], fuse[FB_PRINT_LO]};
    if (strap[SB_BOOT_HIGH]) begin
      boot_mode = BOOT_FLASH;
    end else if (strap[SB_BOOT_LOW]) begin
      boot_mode = BOOT_DL;
    end else begin
      boot_mode = BOOT_NONE;
    end
    sdio_sample_rise = strap[SB_SMP_EDGE];
    sdio_output_rise = strap[SB_OUT_EDGE];
    case (pol)
      2'h0: print_serial = 1'b1;
      2'h1: print_serial = ~strap[SB_BOOT_LOW];
      2'h2: print_serial = strap[SB_BOOT_LOW];
      default: print_serial = 1'b0;
    endcase
    if (fuse[FB_USB_DIS]) begin
      print_usb = 1'b0;
    end else begin
      print_usb = ~fuse[FB_USB_PRTDIS];
    end
    case ({fuse[FB_PAD_DBGDIS], fuse[FB_USB_DBGDIS]})
      2'b00: begin
        if (!fuse[FB_DBG_SELEN]) begin
          debug_source = DBG_USB;
        end else if (strap[SB_DBG_SRC]) begin
          debug_source = DBG_USB;
        end else begin
          debug_source = DBG_PINS;
        end
      end
      2'b10: debug_source = DBG_USB;
      2'b01: debug_source = DBG_PINS;
      default: debug_source = DBG_OFF;
    endcase
  end

endmodule

/* File: rtl/bsd_top.sv */
// Notes on behaviour
// - A high boot-select-high strap selects flash boot regardless.
// - High strap 0 with low strap 1 selects joint download boot.
// - Sample-edge strap 0 samples SDIO on falling, 1 on rising edge.
// - Output-edge strap 0 drives SDIO on falling, 1 on rising edge.
// - ROM messages go to serial, USB bridge or both; both by default.
// - Policy 0 always prints serially; 1 only if low strap is 0.
// - Policy 2 prints only if low strap is 1; policy 3 never prints.
// - With the bridge enabled, its print-disable fuse gates printing.
// - A set bridge-disable fuse stops USB printing outright.
// - Both debug disables 0 and select-enable 0 pick the USB bridge.
// - With select-enable 1 the debug strap picks USB (1) or pins (0).
// - Single disables pick the other source; both disable debug.
// - Straps are captured once at reset and held until power-down; here each reset clears the latch and captures them again.
// - Fuses read 0 unprogrammed and a programmed 1 never clears; here reset clears the fuse array.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module bsd_top
  import bsd_pkg::*;
#(
  parameter int HOLD_CYCLES = STRAP_HOLD_CYC
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  boot_select_low_strap,
  input  wire logic                  boot_select_high_strap,
  input  wire logic                  sdio_sample_edge_strap,
  input  wire logic                  sdio_output_edge_strap,
  input  wire logic                  debug_source_strap,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       options_valid,
  output logic      [1:0]            boot_mode,
  output logic                       sdio_sample_rise,
  output logic                       sdio_output_rise,
  output logic                       print_serial,
  output logic                       print_usb,
  output logic      [1:0]            debug_source
);

  // A hold under three cycles would latch the cleared synchroniser, not
  // the pins, and the hold counter is only 24 bits wide.
  if (HOLD_CYCLES < 3 || HOLD_CYCLES > 2**24 - 1) begin : g_hold_chk
    $error("HOLD_CYCLES out of range");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_DONE = 2'b10
  } bsd_state_e;

  typedef struct packed {
    bsd_state_e          st;
    logic [23:0]         cnt;
    logic [STRAP_W-1:0]  s1;
    logic [STRAP_W-1:0]  s2;
    logic [STRAP_W-1:0]  s3;
    logic [STRAP_W-1:0]  latch;
    logic [FUSE_W-1:0]   fuse;
    logic                valid;
    logic [1:0]          boot;
    logic                smp;
    logic                outp;
    logic                pser;
    logic                pusb;
    logic [1:0]          dbg;
    logic                aw_got;
    logic [7:0]          aw_addr;
    logic                w_got;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                aw_rdy;
    logic                w_rdy;
    logic                ar_rdy;
  } bsd_state_s;

  bsd_state_s q;
  bsd_state_s d;

  logic [STRAP_W-1:0] pins;
  logic [1:0]         dec_boot;
  logic               dec_smp;
  logic               dec_out;
  logic               dec_pser;
  logic               dec_pusb;
  logic [1:0]         dec_dbg;

  assign pins = {debug_source_strap, sdio_output_edge_strap,
                 sdio_sample_edge_strap, boot_select_high_strap,
                 boot_select_low_strap};

  // Decoder works on the latched straps and stored fuses only.
  bsd_decode u_dec (
    .strap            (q.latch),
    .fuse             (q.fuse),
    .boot_mode        (dec_boot),
    .sdio_sample_rise (dec_smp),
    .sdio_output_rise (dec_out),
    .print_serial     (dec_pser),
    .print_usb        (dec_pusb),
    .debug_source     (dec_dbg)
  );

  // Reads the register at a word address.
  function automatic logic [31:0] rd_reg(input logic [7:0] a,
                                         input bsd_state_s s);
    case (a)
      OFS_STRAP:  rd_reg = {27'h0, s.latch};
      OFS_FUSE:   rd_reg = {25'h0, s.fuse};
      OFS_DECODE: rd_reg = {22'h0, s.dbg, s.pusb, s.pser, s.outp, s.smp,
                            s.boot, 1'b0, s.valid};
      OFS_ID:     rd_reg = ID_VALUE;
      default:    rd_reg = 32'h0;
    endcase
  endfunction

  // True for any mapped word address.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_STRAP) || (a == OFS_FUSE) || (a == OFS_FPROG) ||
             (a == OFS_DECODE) || (a == OFS_ID);
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------

  // Capture sequence, decode hold and the AXI4-Lite slave.
  always_comb begin
    d = q;
    // Three-stage synchroniser on the strap pins.
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    case (q.st)
      ST_HOLD: begin
        if (q.s2 == q.s3) begin
          if (q.cnt >= 24'(HOLD_CYCLES - 1)) begin
            d.latch = q.s3;
            d.st    = ST_DONE;
          end else begin
            d.cnt = q.cnt + 24'h1;
          end
        end else begin
          d.cnt = 24'h0;
        end
      end
      ST_DONE: begin
        // Latch is never rewritten here.
        d.valid = 1'b1;
        if (!q.valid) begin
          d.boot = dec_boot;
          d.smp  = dec_smp;
          d.outp = dec_out;
          d.pser = dec_pser;
          d.pusb = dec_pusb;
          d.dbg  = dec_dbg;
        end
      end
      default: d.st = ST_HOLD;
    endcase

    // Write channel collection.
    if (s_axi_awvalid && q.aw_rdy) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.w_rdy) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if ({q.aw_addr[7:2], 2'b00} == OFS_FPROG) begin
        // Fuse bits only ever go from 0 to 1.
        if (q.w_strb[0] && q.st == ST_HOLD) begin
          d.fuse = q.fuse | q.w_data[FUSE_W-1:0];
        end
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Read channel.
    if (s_axi_arvalid && q.ar_rdy) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_reg({s_axi_araddr[7:2], 2'b00}, q);
      d.rresp  = mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY
                                                    : RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Ready flags are registered so every bus output leaves a flip-flop;
    // a channel is ready whenever it holds nothing and no answer waits.
    d.aw_rdy = !d.aw_got && !d.bvalid;
    d.w_rdy  = !d.w_got && !d.bvalid;
    d.ar_rdy = !d.rvalid;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------

  // Synchronous reset; fuse array is cleared only by reset here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.st    <= ST_HOLD;
      q.latch <= STRAP_RESET;
      q.fuse  <= FUSE_RESET;
      q.boot  <= BOOT_NONE;
      q.dbg   <= DBG_OFF;
    end else begin
      q <= d;
    end
  end

  // Output drive, all straight from flip-flops.
  assign s_axi_awready    = q.aw_rdy;
  assign s_axi_wready     = q.w_rdy;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_arready    = q.ar_rdy;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign options_valid    = q.valid;
  assign boot_mode        = q.boot;
  assign sdio_sample_rise = q.smp;
  assign sdio_output_rise = q.outp;
  assign print_serial     = q.pser;
  assign print_usb        = q.pusb;
  assign debug_source     = q.dbg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  flash_boot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.valid) && q.latch[SB_BOOT_HIGH] |-> boot_mode == BOOT_FLASH)
    else $error("flash boot not chosen");
  dl_boot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.valid) && q.latch[1:0] == 2'b01 |-> boot_mode == BOOT_DL)
    else $error("download boot not chosen");
  smp_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid |-> sdio_sample_rise == q.latch[SB_SMP_EDGE])
    else $error("sample edge wrong");
  out_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid |-> sdio_output_rise == q.latch[SB_OUT_EDGE])
    else $error("output edge wrong");
  ser_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[1:0] == 2'h3 |-> !print_serial)
    else $error("serial print not off");
  ser_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[1:0] == 2'h0 |-> print_serial)
    else $error("serial print not on");
  usb_dis_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[FB_USB_DIS] |-> !print_usb)
    else $error("usb print not off");
  usb_prt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && !q.fuse[FB_USB_DIS] |-> print_usb == !q.fuse[FB_USB_PRTDIS])
    else $error("usb print wrong");
  dbg_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[5:4] == 2'b11 |-> debug_source == DBG_OFF)
    else $error("debug not off");
  dbg_def_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[6:4] == 3'b000 |-> debug_source == DBG_USB)
    else $error("debug default wrong");
  dbg_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid && q.fuse[6:4] == 3'b100 |->
      debug_source == (q.latch[SB_DBG_SRC] ? DBG_USB : DBG_PINS))
    else $error("debug strap ignored");
  hold_const_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.valid |=> $stable(boot_mode) && $stable(q.latch) && options_valid)
    else $error("options changed");
  inactive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.valid |-> boot_mode == BOOT_NONE && debug_source == DBG_OFF)
    else $error("options early");
  fuse_mono_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (($past(q.fuse) & ~q.fuse) == '0))
    else $error("fuse bit cleared");

endmodule

/* File: test/bsd_strap_model.sv */
`timescale 1ns/1ns
module bsd_strap_model (
  input  wire logic       aclk,
  input  wire logic [4:0] levels,
  input  wire logic       free,
  output logic      [4:0] pins
);

  // ------------------------------------------------------------------
  // Board side of the strap pins.
  // ------------------------------------------------------------------
  // Every strap is driven hard until the bench frees the pins, so none is
  // ever left floating. Once freed, the pins carry ordinary IO traffic,
  // which here changes every cycle so a leaky latch shows at once.
  always_ff @(posedge aclk) begin
    pins <= free ? ~pins : levels;
  end

endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import bsd_pkg::*;

  // ------------------------------------------------------------------
  // Signals and the design.
  // ------------------------------------------------------------------
  localparam int HOLD = 20;
  typedef struct {
    logic [4:0] s;
    logic [6:0] f;
    logic [7:0] e;
  } bsd_row_s;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic [4:0]  levels  = 5'h00;
  logic        free    = 1'b0;
  logic [4:0]  pins;
  logic        awready, wready, bvalid, arready, rvalid, options_valid;
  logic        smp, outr, ps, pu;
  logic [1:0]  bresp, rresp, boot, dbg;
  logic [31:0] rdata, q;
  logic [1:0]  r;
  int          bad_count = 0;
  int          checks    = 0;

  // Strap levels per row, fuse image, expected {dbg,usb,ser,out,smp,boot}.
  bsd_row_s rows [11] = '{
    '{5'h02, 7'h00, 8'h71}, '{5'h03, 7'h01, 8'h61}, '{5'h01, 7'h02, 8'h72},
    '{5'h04, 7'h01, 8'h74}, '{5'h08, 7'h0a, 8'h48}, '{5'h0e, 7'h07, 8'h4d},
    '{5'h11, 7'h4c, 8'h52}, '{5'h00, 7'h40, 8'hb0}, '{5'h00, 7'h50, 8'h70},
    '{5'h12, 7'h60, 8'hb1}, '{5'h1f, 7'h3b, 8'h0d}};

  bsd_top #(.HOLD_CYCLES(HOLD)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .boot_select_low_strap(pins[0]), .boot_select_high_strap(pins[1]),
    .sdio_sample_edge_strap(pins[2]), .sdio_output_edge_strap(pins[3]),
    .debug_source_strap(pins[4]),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .options_valid(options_valid), .boot_mode(boot),
    .sdio_sample_rise(smp), .sdio_output_rise(outr), .print_serial(ps),
    .print_usb(pu), .debug_source(dbg));

  bsd_strap_model i_straps (
    .aclk(aclk), .levels(levels), .free(free), .pins(pins));

  // 10 MHz clock.
  initial begin
    forever #50 aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------------
  // Ends the run with the verdict.
  task automatic results();
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one value and counts a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One AXI4-Lite write or read; each channel drops at its own handshake.
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    logic [2:0] p;
    logic [2:0] t;
    int         n;
    @(posedge aclk);
    p = we ? 3'h7 : 3'h5;
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= we;
    wvalid  <= we;
    bready  <= we;
    arvalid <= !we;
    rready  <= !we;
    for (n = 0; n < 50 && p != 3'h0; n++) begin
      @(negedge aclk);
      t[0] = we ? (awvalid && awready) : (arvalid && arready);
      t[1] = wvalid && wready;
      t[2] = we ? (bvalid && bready) : (rvalid && rready);
      if (t[2]) begin
        q = rdata;
        r = we ? bresp : rresp;
      end
      @(posedge aclk);
      if (t[0]) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (t[1]) wvalid <= 1'b0;
      if (t[2]) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
      p = p & ~t;
    end
    if (p != 3'h0) begin
      chk(32'h1, 32'h0);
      results();
    end
  endtask

  // Resets with the given strap levels; outputs must be idle in reset.
  task automatic rst(input logic [4:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    free    <= 1'b0;
    levels  <= s;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(32'({options_valid, boot, dbg, ps, pu}), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Waits for the options, then frees the strap pins for IO use.
  task automatic wait_valid();
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge aclk);
      if (options_valid === 1'b1) break;
    end
    if (n == 200) begin
      chk(32'h1, 32'h0);
      results();
    end
    @(posedge aclk);
    free <= 1'b1;
  endtask

  function automatic logic [7:0] dec();
    return {dbg, pu, ps, outr, smp, boot};
  endfunction

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  // Table rows, then late fuse writes, bad accesses and fuse merging.
  initial begin
    foreach (rows[i]) begin
      rst(rows[i].s);
      if (rows[i].f != 7'h00) begin
        bus(1'b1, OFS_FPROG, {25'h0, rows[i].f});
        chk(32'(r), 32'(RESP_OKAY));
      end
      wait_valid();
      chk(32'(dec()), 32'(rows[i].e));
      chk(32'(dec()), 32'(rows[i].e));
      chk(32'(dec()), 32'(rows[i].e));
      bus(1'b0, OFS_STRAP, 32'h0);
      chk(q, {27'h0, rows[i].s});
      bus(1'b0, OFS_FUSE, 32'h0);
      chk(q, {25'h0, rows[i].f});
      bus(1'b0, OFS_DECODE, 32'h0);
      chk(q, {22'h0, rows[i].e, 2'h1});
    end
    bus(1'b1, OFS_FPROG, 32'h40);
    chk(32'(r), 32'(RESP_OKAY));
    bus(1'b0, OFS_FUSE, 32'h0);
    chk(q, 32'h3b);
    chk(32'(dec()), 32'h0d);
    bus(1'b1, OFS_STRAP, 32'h1f);
    chk(32'(r), 32'(RESP_SLVERR));
    bus(1'b0, 8'h14, 32'h0);
    chk({q[29:0], r}, {30'h0, RESP_SLVERR});
    bus(1'b0, OFS_ID, 32'h0);
    chk(q, ID_VALUE);
    rst(5'h01);
    bus(1'b1, OFS_FPROG, 32'h1);
    bus(1'b1, OFS_FPROG, 32'h2);
    wait_valid();
    bus(1'b0, OFS_FUSE, 32'h0);
    chk(q, 32'h3);
    chk(32'(dec()), 32'h62);
    results();
  end

endmodule
